// >>> inc/enc_consts.vh
// Constants for the encoder configuration map: offsets, reset values, codes.
// Assumes inclusion by bare name from the rtl files; definitions only.
`ifndef ENC_CONSTS_VH
`define ENC_CONSTS_VH

// Seven-bit bus address of the device (arbitrary value)
`define ENC_DEV_ADDR 7'h5A

// Map regions
`define ENC_PIX_LAST 16'h01FF
`define ENC_COL_FIRST 16'h0400
`define ENC_COL_LAST 16'h041F

// Single-byte registers
`define ENC_A_OFFSET_TRIM 16'h0880
`define ENC_B_OFFSET_TRIM 16'h0881
`define ENC_AB_MAG_BAL_TRIM 16'h0882
`define ENC_AB_GAIN_TRIM 16'h0883
`define ENC_QUAD_OUT_CTRL 16'h0884
`define ENC_INDEX_OUT_CTRL 16'h0885
`define ENC_LED_CUR_SEL 16'h0886
`define ENC_LED_LOOP_CTRL 16'h0887
`define ENC_THERMAL_TRIP 16'h0888
`define ENC_IRQ_MASK_STATUS 16'h0889
`define ENC_AMP_ENABLE 16'h088A
`define ENC_BUF_CMP_EN_N 16'h088B
`define ENC_PWR_UP_MARKER 16'h088C
`define ENC_ANA_MON_CTRL 16'h088D
`define ENC_MARKER_CHECK 16'h088E
`define ENC_LED_CUR_LEVEL 16'h088F

// Reset values
`define ENC_RST_ZERO 8'h00
`define ENC_RST_LED_CUR_SEL 8'h10
`define ENC_RST_LED_LOOP 8'h26
`define ENC_RST_THERMAL 8'hCC
`define ENC_RST_AMP_ENABLE 8'hFF
`define ENC_RST_ANA_MON 8'h01
`define ENC_RST_LED_LEVEL 8'h10

// Marker values
`define ENC_MARKER_EXPECT 8'hAA
`define ENC_MARKER_GOOD 8'h0A

// Interrupt byte bit positions and writable mask bits
`define ENC_IRQ_MASK_SHUT 0
`define ENC_IRQ_MASK_ALARM 1
`define ENC_IRQ_STAT_SHUT 4
`define ENC_IRQ_STAT_ALARM 5
`define ENC_IRQ_WR_MASK 8'h0F

// Column route codes
`define ENC_ROUTE_LAST 4'h5

`endif

// >>> rtl/enc_config_map.v
// Configuration memory of an optical encoder sensor: pixel enables, column
// routes, control bytes and read-only status, written over a two-wire port.
// Assumes all inputs synchronous to clock_i; sda driven open-drain outside.
//
// Notes on behaviour
// [R1] 4096 pixel bits in bytes 0x000-0x1FF
// [R2] 64 route nibbles in bytes 0x400-0x41F
// [R3] Enabled pixel feeds its column's chosen output
// [R4] Column nibble picks one of six outputs
// [R5] Byte address is row*8 plus group code
// [R6] Pixel and route storage volatile, no reset value
// [R7] Master reloads patterns after every power-up
// [R8] Without controller, external 1K memory supplies image
// [R9] Trims, controls, interrupt zero; LED, loop, thermal preset
// [R10] Amplifier enable byte resets to all ones
// [R11] Buffer/comparator enable byte active low, resets zero
// [R12] Loader image writes 0xAA to marker byte
// [R13] Marker check reads 0x0A after good load
// [R14] LED level byte read-only, powers up 0x10
// [R15] Analog monitor byte resets to 0x01
// [R16] Byte LSB is leftmost pixel, MSB rightmost
// [R17] Codes 0-5 route A+..Z-, others shunt
// [R18] Latched thermal status cleared by interrupt byte read
// [R19] Unimplemented ranges ignore writes, read zero
// [R20] Sixteen-bit address selects one byte
`timescale 1ns/1ps
`default_nettype none
`include "enc_consts.vh"

module enc_config_map (
  input wire clock_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_n_o,
  input wire thermal_shutdown_event_i,
  input wire thermal_alarm_event_i,
  input wire boot_load_done_i,
  input wire [7:0] led_level_i,
  output reg [4095:0] pixel_active_o,
  output wire [383:0] column_route_o,
  output reg [7:0] a_offset_trim_o,
  output reg [7:0] b_offset_trim_o,
  output reg [7:0] ab_magnitude_balance_trim_o,
  output reg [7:0] ab_common_gain_trim_o,
  output reg [7:0] quad_output_control_o,
  output reg [7:0] index_output_control_o,
  output reg [7:0] led_current_select_o,
  output reg [7:0] led_loop_control_o,
  output reg [7:0] thermal_trip_trim_o,
  output reg [7:0] amp_enable_o,
  output reg [7:0] buffer_comparator_enable_n_o,
  output reg [7:0] analog_monitor_control_o,
  output reg irq_n_o,
  output reg shutdown_o
);

  // Bus side of the two-wire slave
  wire bus_wr; // One-cycle write strobe
  wire bus_rd; // One-cycle read strobe, byte already loaded
  wire [15:0] bus_addr; // Byte address of current access
  wire [7:0] bus_wdata; // Write data byte
  reg [7:0] bus_rdata; // Read data byte for the slave

  // Route nibble storage, two columns per byte
  reg [255:0] column_route_nibble;

  // Interrupt byte: masks in low half, sticky status in high half
  reg [7:0] irq_mask_status;

  // Marker byte and its check result
  reg [7:0] power_up_marker;
  reg marker_ok; // Good master-mode load seen

  // LED level sample, read-only
  reg [7:0] led_current_level;

  // Region decodes
  wire in_pix = (bus_addr <= `ENC_PIX_LAST); // [R1]
  wire in_col = (bus_addr >= `ENC_COL_FIRST) && (bus_addr <= `ENC_COL_LAST); // [R2]

  // Group code to physical position: codes run 000,100,001,101,...
  wire [2:0] grp_pos = {bus_addr[1:0], bus_addr[2]}; // [R5]
  wire [5:0] pix_row = bus_addr[8:3]; // [R5]
  wire [11:0] pix_base = {pix_row, grp_pos, 3'b000};
  wire [7:0] col_base = {bus_addr[4:0], 3'b000};

  // Interrupt byte read clears latched status
  wire irq_read = bus_rd && (bus_addr == `ENC_IRQ_MASK_STATUS); // [R18]

  // Protocol engine
  enc_i2c_slave u_slave (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .wr_o(bus_wr),
    .rd_o(bus_rd),
    .addr_o(bus_addr),
    .wdata_o(bus_wdata),
    .rdata_i(bus_rdata)
  );

  // Pixel and route storage: deliberately no reset, contents undefined
  // at power-up until the master reloads them
  always @(posedge clock_i) begin
    if (bus_wr && in_pix) begin
      // LSB lands on leftmost pixel of the group
      pixel_active_o[pix_base +: 8] <= bus_wdata; // [R1] [R5] [R6] [R16]
    end
    if (bus_wr && in_col) begin
      // Low nibble is the left column of the pair
      column_route_nibble[col_base +: 8] <= bus_wdata; // [R2] [R6]
    end
  end

  // Per-column decode of route nibble to one-hot output select
  // Bit order A+, A-, B+, B-, Z+, Z-; all zero means shunted to ground
  genvar c;
  generate
    for (c = 0; c < 64; c = c + 1) begin : g_col
      reg [5:0] route_sel;
      wire [3:0] nib = column_route_nibble[c*4 +: 4];
      // Registered so the port comes from a flop; one cycle behind storage
      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          route_sel <= 6'h00;
        end else if (nib <= `ENC_ROUTE_LAST) begin
          route_sel <= 6'h01 << nib[2:0]; // [R4] [R17]
        end else begin
          route_sel <= 6'h00; // [R17]
        end
      end
      // Pixel enables gate this select outside, per pixel of the column
      assign column_route_o[c*6 +: 6] = route_sel; // [R3]
    end
  endgenerate

  // Control bytes written by software
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      a_offset_trim_o <= `ENC_RST_ZERO; // [R9]
      b_offset_trim_o <= `ENC_RST_ZERO; // [R9]
      ab_magnitude_balance_trim_o <= `ENC_RST_ZERO; // [R9]
      ab_common_gain_trim_o <= `ENC_RST_ZERO; // [R9]
      quad_output_control_o <= `ENC_RST_ZERO; // [R9]
      index_output_control_o <= `ENC_RST_ZERO; // [R9]
      led_current_select_o <= `ENC_RST_LED_CUR_SEL; // [R9]
      led_loop_control_o <= `ENC_RST_LED_LOOP; // [R9]
      thermal_trip_trim_o <= `ENC_RST_THERMAL; // [R9]
      amp_enable_o <= `ENC_RST_AMP_ENABLE; // [R10]
      buffer_comparator_enable_n_o <= `ENC_RST_ZERO; // [R11]
      power_up_marker <= `ENC_RST_ZERO;
      analog_monitor_control_o <= `ENC_RST_ANA_MON; // [R15]
    end else if (bus_wr) begin
      // Unlisted addresses fall through and change nothing
      case (bus_addr)
        `ENC_A_OFFSET_TRIM: begin
          a_offset_trim_o <= bus_wdata;
        end
        `ENC_B_OFFSET_TRIM: begin
          b_offset_trim_o <= bus_wdata;
        end
        `ENC_AB_MAG_BAL_TRIM: begin
          ab_magnitude_balance_trim_o <= bus_wdata;
        end
        `ENC_AB_GAIN_TRIM: begin
          ab_common_gain_trim_o <= bus_wdata;
        end
        `ENC_QUAD_OUT_CTRL: begin
          quad_output_control_o <= bus_wdata;
        end
        `ENC_INDEX_OUT_CTRL: begin
          index_output_control_o <= bus_wdata;
        end
        `ENC_LED_CUR_SEL: begin
          led_current_select_o <= bus_wdata;
        end
        `ENC_LED_LOOP_CTRL: begin
          led_loop_control_o <= bus_wdata;
        end
        `ENC_THERMAL_TRIP: begin
          thermal_trip_trim_o <= bus_wdata;
        end
        `ENC_AMP_ENABLE: begin
          amp_enable_o <= bus_wdata;
        end
        `ENC_BUF_CMP_EN_N: begin
          buffer_comparator_enable_n_o <= bus_wdata; // [R11]
        end
        `ENC_PWR_UP_MARKER: begin
          power_up_marker <= bus_wdata; // [R12]
        end
        `ENC_ANA_MON_CTRL: begin
          analog_monitor_control_o <= bus_wdata; // [R15]
        end
        default: begin
          // Read-only and unimplemented bytes ignore writes
        end
      endcase
    end
  end

  // Interrupt masks and sticky thermal status
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_status <= `ENC_RST_ZERO; // [R9]
    end else begin
      // Mask half follows software writes
      if (bus_wr && bus_addr == `ENC_IRQ_MASK_STATUS) begin
        irq_mask_status[3:0] <= bus_wdata[3:0];
      end
      // Set beats the clearing read, so an event in the clearing cycle is kept
      if (thermal_shutdown_event_i) begin
        irq_mask_status[`ENC_IRQ_STAT_SHUT] <= 1'b1; // [R18]
      end else if (irq_read) begin
        irq_mask_status[`ENC_IRQ_STAT_SHUT] <= 1'b0; // [R18]
      end
      if (thermal_alarm_event_i) begin
        irq_mask_status[`ENC_IRQ_STAT_ALARM] <= 1'b1; // [R18]
      end else if (irq_read) begin
        irq_mask_status[`ENC_IRQ_STAT_ALARM] <= 1'b0; // [R18]
      end
    end
  end

  // Interrupt pin and shutdown follow the latched status
  // One cycle behind the status byte; latency is harmless here
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_n_o <= 1'b1;
      shutdown_o <= 1'b0;
    end else begin
      irq_n_o <= ~((irq_mask_status[`ENC_IRQ_STAT_SHUT] & irq_mask_status[`ENC_IRQ_MASK_SHUT]) |
                   (irq_mask_status[`ENC_IRQ_STAT_ALARM] & irq_mask_status[`ENC_IRQ_MASK_ALARM])); // [R18]
      shutdown_o <= irq_mask_status[`ENC_IRQ_STAT_SHUT]; // [R18]
    end
  end

  // Marker check: judged when the loader reports its sequence done
  // A later rewrite of the marker does not revoke a good load
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      marker_ok <= 1'b0;
    end else if (boot_load_done_i && power_up_marker == `ENC_MARKER_EXPECT) begin
      marker_ok <= 1'b1; // [R13]
    end
  end

  // LED level sampled each cycle
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      led_current_level <= `ENC_RST_LED_LEVEL; // [R14]
    end else begin
      led_current_level <= led_level_i; // [R14]
    end
  end

  // Read data mux, one byte per address
  always @* begin
    bus_rdata = 8'h00; // [R19]
    if (in_pix) begin
      bus_rdata = pixel_active_o[pix_base +: 8]; // [R16]
    end else if (in_col) begin
      bus_rdata = column_route_nibble[col_base +: 8];
    end else begin
      case (bus_addr)
        `ENC_A_OFFSET_TRIM: bus_rdata = a_offset_trim_o;
        `ENC_B_OFFSET_TRIM: bus_rdata = b_offset_trim_o;
        `ENC_AB_MAG_BAL_TRIM: bus_rdata = ab_magnitude_balance_trim_o;
        `ENC_AB_GAIN_TRIM: bus_rdata = ab_common_gain_trim_o;
        `ENC_QUAD_OUT_CTRL: bus_rdata = quad_output_control_o;
        `ENC_INDEX_OUT_CTRL: bus_rdata = index_output_control_o;
        `ENC_LED_CUR_SEL: bus_rdata = led_current_select_o;
        `ENC_LED_LOOP_CTRL: bus_rdata = led_loop_control_o;
        `ENC_THERMAL_TRIP: bus_rdata = thermal_trip_trim_o;
        `ENC_IRQ_MASK_STATUS: bus_rdata = irq_mask_status;
        `ENC_AMP_ENABLE: bus_rdata = amp_enable_o;
        `ENC_BUF_CMP_EN_N: bus_rdata = buffer_comparator_enable_n_o;
        `ENC_PWR_UP_MARKER: bus_rdata = power_up_marker;
        `ENC_ANA_MON_CTRL: bus_rdata = analog_monitor_control_o;
        `ENC_MARKER_CHECK: bus_rdata = marker_ok ? `ENC_MARKER_GOOD : `ENC_RST_ZERO; // [R13]
        `ENC_LED_CUR_LEVEL: bus_rdata = led_current_level; // [R14]
        default: bus_rdata = 8'h00; // [R19]
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> rtl/enc_i2c_slave.v
// Byte-level two-wire slave with 16-bit register address.
// Assumes scl_i and sda_i synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "enc_consts.vh"

module enc_i2c_slave (
  input wire clock_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n_o,
  output reg wr_o,
  output reg rd_o,
  output reg [15:0] addr_o,
  output reg [7:0] wdata_o,
  input wire [7:0] rdata_i
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DEV = 3'h1;
  localparam [2:0] ST_AHI = 3'h2;
  localparam [2:0] ST_ALO = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;

  reg scl_q; // Previous line levels for edge detection
  reg sda_q;
  reg [2:0] state;
  reg [3:0] bitcnt; // 8 = ack slot, 9 = ack slot over
  reg [7:0] shreg;
  reg rw; // Direction bit of last device address
  reg inc_pending; // Read address advances at next byte start

  wire start = scl_i & scl_q & sda_q & ~sda_i;
  wire stop = scl_i & scl_q & ~sda_q & sda_i;
  wire rise = scl_i & ~scl_q;
  wire fall = ~scl_i & scl_q;

  // Protocol engine; start and stop override any bit phase
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      inc_pending <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      addr_o <= 16'h0000;
      wdata_o <= 8'h00;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      if (start) begin
        state <= ST_DEV;
        bitcnt <= 4'h0;
        sda_oe_n_o <= 1'b1;
        inc_pending <= 1'b0;
      end else if (stop) begin
        state <= ST_IDLE;
        sda_oe_n_o <= 1'b1;
      end else if (state != ST_IDLE && rise) begin
        bitcnt <= bitcnt + 4'h1;
        if (bitcnt < 4'h8 && state != ST_RDATA) begin
          shreg <= {shreg[6:0], sda_i};
        end
        // Read address advances at next byte
        if (bitcnt == 4'h0 && state == ST_RDATA && inc_pending) begin
          addr_o <= addr_o + 16'h0001; // [R20]
          inc_pending <= 1'b0;
        end
        // Master not-acknowledge ends the read
        if (bitcnt == 4'h8 && state == ST_RDATA && sda_i) begin
          state <= ST_IDLE;
        end
      end else if (state != ST_IDLE && fall) begin
        if (bitcnt == 4'h8) begin
          sda_oe_n_o <= (state == ST_RDATA); // Ack by pulling low
          case (state)
            ST_DEV: begin
              if (shreg[7:1] == `ENC_DEV_ADDR) begin
                rw <= shreg[0];
              end else begin
                state <= ST_IDLE;
                sda_oe_n_o <= 1'b1;
              end
            end
            ST_AHI: addr_o[15:8] <= shreg; // [R20]
            ST_ALO: addr_o[7:0] <= shreg;
            ST_WDATA: begin
              wr_o <= 1'b1;
              wdata_o <= shreg;
            end
            default: ;
          endcase
        end else if (bitcnt == 4'h9) begin
          bitcnt <= 4'h0;
          sda_oe_n_o <= 1'b1;
          case (state)
            ST_DEV: begin
              state <= rw ? ST_RDATA : ST_AHI;
              if (rw) begin
                shreg <= rdata_i;
                sda_oe_n_o <= rdata_i[7];
                rd_o <= 1'b1;
                inc_pending <= 1'b1;
              end
            end
            ST_AHI: state <= ST_ALO;
            ST_ALO: state <= ST_WDATA;
            ST_WDATA: addr_o <= addr_o + 16'h0001;
            ST_RDATA: begin
              shreg <= rdata_i;
              sda_oe_n_o <= rdata_i[7];
              rd_o <= 1'b1;
              inc_pending <= 1'b1;
            end
            default: ;
          endcase
        end else if (state == ST_RDATA && bitcnt != 4'h0) begin
          shreg <= {shreg[6:0], 1'b0};
          sda_oe_n_o <= shreg[6];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/enc_config_map_properties.sv
// Port-level checks for the configuration map.
// Assumes one clock domain and bind onto the design top.
`timescale 1ns/1ps
`default_nettype none
module enc_map_props (
  input wire clock_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_oe_n_o,
  input wire thermal_shutdown_event_i,
  input wire thermal_alarm_event_i,
  input wire [383:0] column_route_o,
  input wire [7:0] a_offset_trim_o,
  input wire [7:0] quad_output_control_o,
  input wire [7:0] led_current_select_o,
  input wire [7:0] led_loop_control_o,
  input wire [7:0] thermal_trip_trim_o,
  input wire [7:0] amp_enable_o,
  input wire [7:0] buffer_comparator_enable_n_o,
  input wire [7:0] analog_monitor_control_o,
  input wire irq_n_o,
  input wire shutdown_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Live during reset
  property p_rst_ctl;
    disable iff (1'b0) rst_i && $past(rst_i) |-> {a_offset_trim_o, quad_output_control_o, led_current_select_o,
      led_loop_control_o, thermal_trip_trim_o, amp_enable_o, buffer_comparator_enable_n_o,
      analog_monitor_control_o} == 64'h00001026CCFF0001;
  endproperty
  property p_rst_sig;
    disable iff (1'b0) rst_i && $past(rst_i) |-> irq_n_o && !shutdown_o && sda_oe_n_o && column_route_o == 384'h0;
  endproperty
  // Event to pin in two clocks
  property p_shut_set;
    thermal_shutdown_event_i |-> ##2 shutdown_o;
  endproperty
  property p_shut_rise;
    $rose(shutdown_o) |-> $past(thermal_shutdown_event_i, 2);
  endproperty
  // No read can clear while scl stays high
  property p_shut_hold;
    (shutdown_o && scl_i) [*6] |=> shutdown_o;
  endproperty
  // Interrupt needs event or mask write
  property p_irq_fall;
    $fell(irq_n_o) |-> $past(thermal_shutdown_event_i, 2) || $past(thermal_alarm_event_i, 2) || !$past(sda_oe_n_o);
  endproperty
  // Device moves sda only while scl low
  property p_sda_change;
    $changed(sda_oe_n_o) |-> !scl_i;
  endproperty
  // Writes land while scl low
  property p_ctl_stable;
    scl_i [*4] |=> $stable(led_current_select_o) && $stable(a_offset_trim_o) && $stable(amp_enable_o)
      && $stable(analog_monitor_control_o);
  endproperty
  a_rst_ctl: assert property (p_rst_ctl) else $error("control bytes off reset value");
  a_rst_sig: assert property (p_rst_sig) else $error("status pins off reset value");
  a_shut_set: assert property (p_shut_set) else $error("shutdown not latched");
  a_shut_rise: assert property (p_shut_rise) else $error("shutdown without event");
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown dropped on idle bus");
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt without cause");
  a_sda_change: assert property (p_sda_change) else $error("sda moved with scl high");
  a_ctl_stable: assert property (p_ctl_stable) else $error("control byte moved off bus write");
  c_shut: cover property ($rose(shutdown_o));
  c_irq: cover property ($fell(irq_n_o));
  c_ack: cover property ($fell(sda_oe_n_o));
endmodule
`default_nettype wire

// >>> test/enc_i2c_master.sv
// Two-wire master model: controller or image loader.
// Assumes open-drain sda with pull-up; drives at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "enc_consts.vh"
module enc_i2c_master (
  input wire logic clock_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_o
);
  // Idle bus
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Three clocks per phase
  task automatic half();
    repeat (3) @(negedge clock_i);
  endtask
  // Start: sda falls, scl high
  task automatic start();
    @(negedge clock_i);
    sda_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_o = 1'b0;
    half();
    scl_o = 1'b0;
  endtask
  // Stop: sda rises, scl high
  task automatic stop();
    @(negedge clock_i);
    sda_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_o = 1'b1;
    half();
  endtask
  // One bit: set data, sample while scl high
  task automatic bit_io(input logic b, output logic seen);
    @(negedge clock_i);
    sda_o = b;
    half();
    scl_o = 1'b1;
    half();
    seen = sda_i;
    scl_o = 1'b0;
  endtask
  // Byte MSB first, then ack slot
  task automatic put_byte(input logic [7:0] d, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ok = ok & ~s;
  endtask
  // Single-byte write, as used for image reload
  task automatic write_reg(input logic [15:0] a, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    put_byte({`ENC_DEV_ADDR, 1'b0}, ok);
    put_byte(a[15:8], ok); // High address byte first
    put_byte(a[7:0], ok);
    put_byte(d, ok);
    stop();
  endtask
  // Single-byte read ending in nack
  task automatic read_reg(input logic [15:0] a, output logic [7:0] d, output logic ok);
    logic s;
    ok = 1'b1;
    start();
    put_byte({`ENC_DEV_ADDR, 1'b0}, ok);
    put_byte(a[15:8], ok);
    put_byte(a[7:0], ok);
    start();
    put_byte({`ENC_DEV_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, s);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> test/tb_encoder_config_map.sv
// Self-checking bench for the configuration map.
// Assumes inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "enc_consts.vh"
module tb_encoder_config_map;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic shut_ev = 1'b0;
  logic alarm_ev = 1'b0;
  logic boot_done = 1'b0;
  logic [7:0] led_level = 8'h10; // Power-on drive level
  int error_cnt = 0;
  int comparisons = 0;
  wire scl_w;
  wire sda_m;
  wire sda_dev;
  wire sda_oe_n;
  wire sda_w;
  wire irq_n;
  wire shutdown;
  wire [4095:0] pixel_active;
  wire [383:0] column_route;
  wire [7:0] ctl [12]; // Control bytes 0x880-0x888, 0x88A, 0x88B, 0x88D
  // Reset bytes 0x880-0x88F; offset of each output
  localparam logic [7:0] RST_TAB [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h26,
    8'hCC, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h00, 8'h10};
  localparam int CTL_OFS [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 11, 13};
  // Column-group codes, left to right
  localparam logic [2:0] GRP_CODE [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  // Open-drain wire
  assign sda_w = sda_m & (sda_oe_n | sda_dev);
  // 10 MHz clock
  always #50 clock_i = ~clock_i;
  enc_i2c_master master (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl_w), .sda_o(sda_m));
  enc_config_map DUT (
    .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_dev), .sda_oe_n_o(sda_oe_n),
    .thermal_shutdown_event_i(shut_ev), .thermal_alarm_event_i(alarm_ev), .boot_load_done_i(boot_done),
    .led_level_i(led_level), .pixel_active_o(pixel_active), .column_route_o(column_route),
    .a_offset_trim_o(ctl[0]), .b_offset_trim_o(ctl[1]), .ab_magnitude_balance_trim_o(ctl[2]),
    .ab_common_gain_trim_o(ctl[3]), .quad_output_control_o(ctl[4]), .index_output_control_o(ctl[5]),
    .led_current_select_o(ctl[6]), .led_loop_control_o(ctl[7]), .thermal_trip_trim_o(ctl[8]),
    .amp_enable_o(ctl[9]), .buffer_comparator_enable_n_o(ctl[10]), .analog_monitor_control_o(ctl[11]),
    .irq_n_o(irq_n), .shutdown_o(shutdown));
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic ok;
    master.write_reg(a, d, ok);
    check_val(ok, 1'b1, "write ack");
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    logic ok;
    logic [7:0] d;
    master.read_reg(a, d, ok);
    check_val(ok, 1'b1, "read ack");
    check_val(d, exp, what);
  endtask
  // One-cycle pulse on an event input
  task automatic pulse(input int which);
    @(negedge clock_i);
    if (which == 0) shut_ev = 1'b1;
    else if (which == 1) alarm_ev = 1'b1;
    else boot_done = 1'b1;
    @(negedge clock_i);
    shut_ev = 1'b0;
    alarm_ev = 1'b0;
    boot_done = 1'b0;
    repeat (4) @(negedge clock_i);
  endtask
  task automatic t_reset_values();
    for (int i = 0; i < 12; i++) check_val(ctl[i], RST_TAB[CTL_OFS[i]], "reset output");
    for (int a = 0; a < 16; a++) rd_chk(16'h0880 + a, RST_TAB[a], "reset read");
  endtask
  // All group codes of one row, last byte
  task automatic t_pixel();
    for (int g = 0; g < 8; g++) wr({7'h00, 6'd5, GRP_CODE[g]}, {GRP_CODE[g], 5'h0B});
    for (int g = 0; g < 8; g++) check_val(pixel_active[320 + g * 8 +: 8], {GRP_CODE[g], 5'h0B}, "pixels");
    wr(16'h01FF, 8'h96);
    check_val(pixel_active[4088 +: 8], 8'h96, "last pixels");
    rd_chk(16'h01FF, 8'h96, "pixel readback");
  endtask
  // Codes 0..15, then last route byte
  task automatic t_route();
    for (int k = 0; k < 8; k++) wr(16'h0400 + k, {4'(2 * k + 1), 4'(2 * k)});
    wr(16'h041F, 8'h52);
    repeat (3) @(negedge clock_i);
    for (int c = 0; c < 16; c++) check_val(column_route[c * 6 +: 6], (c < 6) ? 6'(1 << c) : 6'h00, "route");
    check_val(column_route[377:372], 6'h04, "route col 62");
    check_val(column_route[383:378], 6'h20, "route col 63");
  endtask
  // Unmapped and read-only writes ignored
  task automatic t_unmapped();
    wr(16'h0000, 8'h3C);
    wr(16'h0200, 8'hC3);
    wr(16'h0420, 8'h5A);
    wr(16'h087F, 8'hA5);
    wr(16'h088F, 8'h77);
    rd_chk(16'h0000, 8'h3C, "pixel alias");
    rd_chk(16'h0400, 8'h10, "route alias");
    rd_chk(16'h0880, 8'h00, "trim alias");
    rd_chk(16'h0200, 8'h00, "unmapped read");
    rd_chk(16'h0420, 8'h00, "unmapped read");
    @(negedge clock_i);
    led_level = 8'h37;
    rd_chk(16'h088F, 8'h37, "led level");
  endtask
  // Status holds until read
  task automatic t_irq();
    wr(16'h0889, 8'hFF);
    rd_chk(16'h0889, 8'h0F, "masks");
    pulse(0);
    repeat (40) @(negedge clock_i);
    check_val({shutdown, irq_n}, 2'b10, "shutdown held");
    rd_chk(16'h0889, 8'h1F, "shutdown status");
    check_val({shutdown, irq_n}, 2'b01, "shutdown cleared");
    pulse(1);
    check_val({shutdown, irq_n}, 2'b00, "alarm");
    rd_chk(16'h0889, 8'h2F, "alarm status");
    wr(16'h0889, 8'h00);
    pulse(1);
    check_val(irq_n, 1'b1, "alarm masked");
    rd_chk(16'h0889, 8'h20, "masked status");
    rd_chk(16'h0889, 8'h00, "status cleared");
  endtask
  task automatic t_marker();
    pulse(2);
    rd_chk(16'h088E, 8'h00, "no marker");
    wr(16'h088C, 8'hAA); // Loader image writes the marker
    wr(16'h088E, 8'h55);
    pulse(2);
    rd_chk(16'h088E, 8'h0A, "marker good");
  endtask
  // Mid-run reset
  task automatic t_reset_again();
    wr(16'h0886, 8'h55);
    check_val(ctl[6], 8'h55, "led select");
    @(negedge clock_i);
    rst_i = 1'b1;
    led_level = 8'h10; // Level back to power-on value
    repeat (4) @(negedge clock_i);
    rst_i = 1'b0;
    @(negedge clock_i);
    t_reset_values();
  endtask
  initial begin
    repeat (16) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    t_reset_values();
    t_pixel();
    t_route();
    t_unmapped();
    t_irq();
    t_marker();
    t_reset_again();
    complete_run();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clock_i);
    error_cnt++;
    complete_run();
  end
endmodule
bind enc_config_map enc_map_props u_props (
  .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o),
  .thermal_shutdown_event_i(thermal_shutdown_event_i), .thermal_alarm_event_i(thermal_alarm_event_i),
  .column_route_o(column_route_o), .a_offset_trim_o(a_offset_trim_o), .quad_output_control_o(quad_output_control_o),
  .led_current_select_o(led_current_select_o), .led_loop_control_o(led_loop_control_o),
  .thermal_trip_trim_o(thermal_trip_trim_o), .amp_enable_o(amp_enable_o),
  .buffer_comparator_enable_n_o(buffer_comparator_enable_n_o),
  .analog_monitor_control_o(analog_monitor_control_o), .irq_n_o(irq_n_o), .shutdown_o(shutdown_o));
`default_nettype wire
